// ### eiesf_map.vh
`ifndef EIESF_MAP_VH
`define EIESF_MAP_VH

// register indexes, byte address is four times the index
`define EIESF_IDX_FCTL 32'hFFFFF318
`define EIESF_IDX_FALL_A 32'hFFFFFC00
`define EIESF_IDX_FALL_B 32'hFFFFFC02
`define EIESF_IDX_FALL_C 32'hFFFFFC06
`define EIESF_IDX_FALL_H 32'hFFFFFC13
`define EIESF_IDX_RISE_A 32'hFFFFFC20
`define EIESF_IDX_RISE_B 32'hFFFFFC22
`define EIESF_IDX_RISE_C 32'hFFFFFC26
`define EIESF_IDX_RISE_H 32'hFFFFFC33
`define EIESF_IDX_STAT 32'hFFFFFE00
`define EIESF_IDX_MASK 32'hFFFFFE01

// implemented bits of each register
`define EIESF_MSK_A 8'h60
`define EIESF_MSK_B 8'h01
`define EIESF_MSK_C 8'h82
`define EIESF_MSK_H 8'hE0
`define EIESF_MSK_FCTL 8'h87
`define EIESF_RST_VAL 8'h00

// field positions
`define EIESF_BIT_PIN2 5
`define EIESF_BIT_PIN3 6
`define EIESF_BIT_PIN0 0
`define EIESF_BIT_PIN7 1
`define EIESF_BIT_PIN1 7
`define EIESF_BIT_PIN4 5
`define EIESF_BIT_PIN5 6
`define EIESF_BIT_PIN6 7
`define EIESF_BIT_DFSEL 7

// sample clock divisors by code
`define EIESF_DIV_0 64
`define EIESF_DIV_1 128
`define EIESF_DIV_2 256
`define EIESF_DIV_3 512
`define EIESF_DIV_4 1024
`define EIESF_DIV_5 32

// timing
`define EIESF_CLK_NS 20
`define EIESF_ANALOG_NS 60
`define EIESF_ANALOG_CYC ((`EIESF_ANALOG_NS + `EIESF_CLK_NS - 1) / `EIESF_CLK_NS)
`define EIESF_SAMPLES 3

`define EIESF_RESP_OKAY 2'b00
`define EIESF_RESP_SLVERR 2'b10

`endif

// ### eiesf_top.v
`timescale 1ns/10ps
`include "eiesf_map.vh"
module eiesf_top #(
    parameter ADDR_W = 14,
    parameter NPIN = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NPIN-1:0] ext_irq_pin,
    output reg [NPIN-1:0] edge_req_q,
    output reg wake_req_q,
    output wire irq
);

localparam [31:0] I_FCTL = `EIESF_IDX_FCTL;
localparam [31:0] I_FA = `EIESF_IDX_FALL_A;
localparam [31:0] I_FB = `EIESF_IDX_FALL_B;
localparam [31:0] I_FC = `EIESF_IDX_FALL_C;
localparam [31:0] I_FH = `EIESF_IDX_FALL_H;
localparam [31:0] I_RA = `EIESF_IDX_RISE_A;
localparam [31:0] I_RB = `EIESF_IDX_RISE_B;
localparam [31:0] I_RC = `EIESF_IDX_RISE_C;
localparam [31:0] I_RH = `EIESF_IDX_RISE_H;
localparam [31:0] I_ST = `EIESF_IDX_STAT;
localparam [31:0] I_MK = `EIESF_IDX_MASK;
localparam integer ANA_CYC_N = `EIESF_ANALOG_CYC;
localparam [1:0] ANA_CYC = ANA_CYC_N[1:0];

////////////////////////////////////////////////////////////////////////////////
// helpers

// map a register address to its slot, 0 means unmapped
function [3:0] slot;
    input [ADDR_W-1:0] a;
    reg [11:0] ix;
    begin
        ix = a[13:2];
        slot = 4'h0;
        if (a[1:0] == 2'b00) begin
            case (ix)
                I_FCTL[11:0]: slot = 4'h1;
                I_FA[11:0]: slot = 4'h2;
                I_FB[11:0]: slot = 4'h3;
                I_FC[11:0]: slot = 4'h4;
                I_FH[11:0]: slot = 4'h5;
                I_RA[11:0]: slot = 4'h6;
                I_RB[11:0]: slot = 4'h7;
                I_RC[11:0]: slot = 4'h8;
                I_RH[11:0]: slot = 4'h9;
                I_ST[11:0]: slot = 4'hA;
                I_MK[11:0]: slot = 4'hB;
                default: slot = 4'h0;
            endcase
        end
    end
endfunction

// gather one enable per pin from the four registers of one direction
function [7:0] pin_map;
    input [7:0] ra;
    input [7:0] rb;
    input [7:0] rc;
    input [7:0] rh;
    begin
        pin_map[0] = rb[`EIESF_BIT_PIN0];
        pin_map[1] = rc[`EIESF_BIT_PIN1];
        pin_map[2] = ra[`EIESF_BIT_PIN2];
        pin_map[3] = ra[`EIESF_BIT_PIN3];
        pin_map[4] = rh[`EIESF_BIT_PIN4];
        pin_map[5] = rh[`EIESF_BIT_PIN5];
        pin_map[6] = rh[`EIESF_BIT_PIN6];
        pin_map[7] = rc[`EIESF_BIT_PIN7];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers and bus

reg [7:0] fctl_q;
reg [7:0] fa_q;
reg [7:0] fb_q;
reg [7:0] fc_q;
reg [7:0] fh_q;
reg [7:0] ra_q;
reg [7:0] rb_q;
reg [7:0] rc_q;
reg [7:0] rh_q;
reg [7:0] stat_q;
reg [7:0] mask_q;

reg aw_full_q;
reg [ADDR_W-1:0] aw_addr_q;
reg w_full_q;
reg [7:0] w_data_q;
reg w_lane_q;
reg [7:0] stat_d;

wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
wire [3:0] wr_slot = slot(aw_addr_q);
wire wr_en = wr_go && w_lane_q;
wire [7:0] wd = w_data_q;
wire [NPIN-1:0] edge_d;

assign s_axi_awready = !aw_full_q;
assign s_axi_wready = !w_full_q;
assign s_axi_arready = !s_axi_rvalid;
assign irq = |(stat_q & mask_q);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_q <= 1'b0;
        aw_addr_q <= {ADDR_W{1'b0}};
        w_full_q <= 1'b0;
        w_data_q <= 8'h00;
        w_lane_q <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `EIESF_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_slot == 4'h0) ? `EIESF_RESP_SLVERR : `EIESF_RESP_OKAY;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// a byte-wide register updates only from lane 0; bit writes are a byte write
always @(posedge aclk) begin
    if (!aresetn) begin
        fctl_q <= `EIESF_RST_VAL;
        fa_q <= `EIESF_RST_VAL;
        fb_q <= `EIESF_RST_VAL;
        fc_q <= `EIESF_RST_VAL;
        fh_q <= `EIESF_RST_VAL;
        ra_q <= `EIESF_RST_VAL;
        rb_q <= `EIESF_RST_VAL;
        rc_q <= `EIESF_RST_VAL;
        rh_q <= `EIESF_RST_VAL;
        mask_q <= `EIESF_RST_VAL;
    end else if (wr_en) begin
        case (wr_slot)
            4'h1: fctl_q <= wd & `EIESF_MSK_FCTL;
            4'h2: fa_q <= wd & `EIESF_MSK_A;
            4'h3: fb_q <= wd & `EIESF_MSK_B;
            4'h4: fc_q <= wd & `EIESF_MSK_C;
            4'h5: fh_q <= wd & `EIESF_MSK_H;
            4'h6: ra_q <= wd & `EIESF_MSK_A;
            4'h7: rb_q <= wd & `EIESF_MSK_B;
            4'h8: rc_q <= wd & `EIESF_MSK_C;
            4'h9: rh_q <= wd & `EIESF_MSK_H;
            4'hB: mask_q <= wd;
            default: mask_q <= mask_q;
        endcase
    end
end

// write-one-to-clear, a new edge in the same cycle wins
always @* begin
    stat_d = stat_q;
    if (wr_en && wr_slot == 4'hA) begin
        stat_d = stat_q & ~wd;
    end
    stat_d = stat_d | edge_d;
end

always @(posedge aclk) begin
    if (!aresetn) begin
        stat_q <= `EIESF_RST_VAL;
    end else begin
        stat_q <= stat_d;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `EIESF_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `EIESF_RESP_OKAY;
        case (slot(s_axi_araddr))
            4'h1: s_axi_rdata <= {24'h000000, fctl_q};
            4'h2: s_axi_rdata <= {24'h000000, fa_q};
            4'h3: s_axi_rdata <= {24'h000000, fb_q};
            4'h4: s_axi_rdata <= {24'h000000, fc_q};
            4'h5: s_axi_rdata <= {24'h000000, fh_q};
            4'h6: s_axi_rdata <= {24'h000000, ra_q};
            4'h7: s_axi_rdata <= {24'h000000, rb_q};
            4'h8: s_axi_rdata <= {24'h000000, rc_q};
            4'h9: s_axi_rdata <= {24'h000000, rh_q};
            4'hA: s_axi_rdata <= {24'h000000, stat_q};
            4'hB: s_axi_rdata <= {24'h000000, mask_q};
            default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `EIESF_RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and analog-equivalent delay filter

reg [NPIN-1:0] s1_q;
reg [NPIN-1:0] s2_q;
reg [NPIN-1:0] s3_q;
reg [NPIN-1:0] sync_q;
reg [NPIN-1:0] alvl_q;
reg [2*NPIN-1:0] acnt_q;

always @(posedge aclk) begin
    if (!aresetn) begin
        s1_q <= {NPIN{1'b0}};
        s2_q <= {NPIN{1'b0}};
        s3_q <= {NPIN{1'b0}};
        sync_q <= {NPIN{1'b0}};
    end else begin
        s1_q <= ext_irq_pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // a change counts only once stages two and three agree
        sync_q <= (s3_q & ~(s2_q ^ s3_q)) | (sync_q & (s2_q ^ s3_q));
    end
end

// a level must hold for the analog delay before it is seen
// one process for all pins keeps a single driver per vector
always @(posedge aclk) begin : p_ana
    integer i;
    for (i = 0; i < NPIN; i = i + 1) begin
        if (!aresetn) begin
            alvl_q[i] <= 1'b0;
            acnt_q[2*i +: 2] <= 2'b00;
        end else if (sync_q[i] == alvl_q[i]) begin
            acnt_q[2*i +: 2] <= 2'b00;
        end else if (acnt_q[2*i +: 2] == ANA_CYC - 2'b01) begin
            alvl_q[i] <= sync_q[i];
            acnt_q[2*i +: 2] <= 2'b00;
        end else begin
            acnt_q[2*i +: 2] <= acnt_q[2*i +: 2] + 2'b01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin-3 digital sampled filter

reg [9:0] dcnt_q;
reg [9:0] dlim;
reg dok;
reg [2:0] sel_q;
reg tick_q;
reg [1:0] smp_q;
reg dlvl_q;

wire [2:0] sel = fctl_q[2:0];
wire dfsel = fctl_q[`EIESF_BIT_DFSEL];

always @* begin
    dok = 1'b1;
    case (sel)
        3'b000: dlim = 10'd`EIESF_DIV_0 - 10'd1;
        3'b001: dlim = 10'd`EIESF_DIV_1 - 10'd1;
        3'b010: dlim = 10'd`EIESF_DIV_2 - 10'd1;
        3'b011: dlim = 10'd`EIESF_DIV_3 - 10'd1;
        3'b100: dlim = 10'd1023;
        3'b101: dlim = 10'd`EIESF_DIV_5 - 10'd1;
        default: begin
            // prohibited codes stop the sampling clock
            dlim = 10'h000;
            dok = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        dcnt_q <= 10'h000;
        sel_q <= 3'b000;
        tick_q <= 1'b0;
    end else begin
        sel_q <= sel;
        tick_q <= 1'b0;
        if (sel_q != sel || !dok) begin
            // restart the divider; samples refill over three ticks
            dcnt_q <= 10'h000;
        end else if (dcnt_q == dlim) begin
            dcnt_q <= 10'h000;
            tick_q <= 1'b1;
        end else begin
            dcnt_q <= dcnt_q + 10'd1;
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        smp_q <= 2'b00;
        dlvl_q <= 1'b0;
    end else if (tick_q) begin
        smp_q <= {smp_q[0], sync_q[3]};
        // a pulse shorter than three samples never reaches dlvl
        if (smp_q == {2{sync_q[3]}}) begin
            dlvl_q <= sync_q[3];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// edge detection

reg [NPIN-1:0] prev_q;
wire [NPIN-1:0] filt;
wire [NPIN-1:0] fen = pin_map(fa_q, fb_q, fc_q, fh_q);
wire [NPIN-1:0] ren = pin_map(ra_q, rb_q, rc_q, rh_q);

// toggling the filter mode may itself look like an edge
assign filt = {alvl_q[7:4], dfsel ? dlvl_q : alvl_q[3], alvl_q[2:0]};
assign edge_d = (ren & filt & ~prev_q) | (fen & ~filt & prev_q);

always @(posedge aclk) begin
    if (!aresetn) begin
        prev_q <= {NPIN{1'b0}};
        edge_req_q <= {NPIN{1'b0}};
        wake_req_q <= 1'b0;
    end else begin
        prev_q <= filt;
        edge_req_q <= edge_d;
        // wake path needs only the system clock here
        wake_req_q <= edge_d[3];
    end
end

endmodule

// ### eiesf_sva.sv
`timescale 1ns/10ps
module eiesf_sva #(
    parameter NPIN = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NPIN-1:0] edge_req_q,
    input wire wake_req_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////
    // reset check must not be disabled by the reset it watches
    reset_idle_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && edge_req_q == '0)
        else $error("outputs not idle after reset");
    write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    read_lat_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rvalid_cause_a: assert property ($rose(s_axi_rvalid) |->
        $past(s_axi_arvalid && s_axi_arready)) else $error("read data without request");
    pulse_one_a: assert property (|edge_req_q |=>
        (edge_req_q & $past(edge_req_q)) == '0) else $error("request longer than a cycle");
    wake_copy_a: assert property ($rose(edge_req_q[3]) |-> ##[0:1] wake_req_q)
        else $error("pin 3 request gave no wake");
endmodule
bind eiesf_top eiesf_sva #(.NPIN(NPIN)) i_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .edge_req_q(edge_req_q), .wake_req_q(wake_req_q));

// ### eiesf_pins.sv
`timescale 1ns/10ps
module eiesf_pins (
    input wire aclk,
    output logic [7:0] pin
);
    // pins are actively driven, so the last level is held
    initial pin = 8'h00;
    task drive(input int i, input logic v);
        @(posedge aclk);
        pin[i] <= v;
    endtask
endmodule

// ### ext_irq_edge_select_filter_tb.sv
`timescale 1ns/10ps
`include "eiesf_map.vh"
module ext_irq_edge_select_filter_tb;
    typedef struct {logic [31:0] idx; logic [7:0] msk; logic [1:0] rsp;} eiesf_row_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awd, wd;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [7:0] rd;
    wire awready, wready, bvalid, arready, rvalid, irq, wake;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] pins, req;
    int err_count, checks, b, wc;
    int pc[8];
    int dv[6] = '{64, 128, 256, 512, 1024, 32};
    logic [31:0] pidx[8] = '{`EIESF_IDX_RISE_B, `EIESF_IDX_RISE_C, `EIESF_IDX_RISE_A,
        `EIESF_IDX_RISE_A, `EIESF_IDX_RISE_H, `EIESF_IDX_RISE_H, `EIESF_IDX_RISE_H,
        `EIESF_IDX_RISE_C};
    logic [7:0] pbit[8] = '{8'h01, 8'h80, 8'h20, 8'h40, 8'h20, 8'h40, 8'h80, 8'h02};
    eiesf_row_t rows[11] = '{'{`EIESF_IDX_FCTL, 8'h87, 2'b00},
        '{`EIESF_IDX_FALL_A, 8'h60, 2'b00}, '{`EIESF_IDX_FALL_B, 8'h01, 2'b00},
        '{`EIESF_IDX_FALL_C, 8'h82, 2'b00}, '{`EIESF_IDX_FALL_H, 8'hE0, 2'b00},
        '{`EIESF_IDX_RISE_A, 8'h60, 2'b00}, '{`EIESF_IDX_RISE_B, 8'h01, 2'b00},
        '{`EIESF_IDX_RISE_C, 8'h82, 2'b00}, '{`EIESF_IDX_RISE_H, 8'hE0, 2'b00},
        '{`EIESF_IDX_MASK, 8'hFF, 2'b00}, '{32'hFFFFF000, 8'h00, 2'b10}};
    eiesf_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_irq_pin(pins), .edge_req_q(req), .wake_req_q(wake), .irq(irq));
    eiesf_pins i_pins (.aclk(aclk), .pin(pins));
    ////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) for (int i = 0; i < 8; i++) if (req[i] === 1'b1) pc[i]++;
    always @(posedge aclk) if (wake === 1'b1) wc++;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ready is high whenever the holding register is empty, so address and data are both taken in the same cycle
    task wr(input logic [31:0] idx, input logic [7:0] d);
        awaddr <= {idx[11:0], 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awd = 1'b0;
        wd = 1'b0;
        while (!(awd && wd)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !awd) begin awd = 1'b1; awvalid <= 1'b0; end
            if (wready === 1'b1 && !wd) begin wd = 1'b1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task rdr(input logic [31:0] idx);
        araddr <= {idx[11:0], 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b1;
        @(posedge aclk);
        rd = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask
    task step(input int p, input logic v, input int n);
        b = pc[p];
        i_pins.drive(p, v);
        cyc(15);
        chk(pc[p] - b, n);
    endtask
    task wrap_up;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        err_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 14'h0000;
        araddr = 14'h0000;
        wdata = 32'h00000000;
        cyc(4);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            rdr(rows[i].idx);
            chk(rd, 8'h00);
            chk(resp, rows[i].rsp);
        end
        foreach (rows[i]) begin
            wr(rows[i].idx, 8'hFF);
            chk(resp, rows[i].rsp);
            rdr(rows[i].idx);
            chk(rd, rows[i].msk);
            wr(rows[i].idx, 8'h00);
        end
        for (int p = 0; p < 8; p++) begin
            wr(pidx[p], pbit[p]);
            step(p, 1'b1, 1);
            step(p, 1'b0, 0);
            wr(pidx[p], 8'h00);
        end
        for (int m = 0; m < 4; m++) begin
            wr(`EIESF_IDX_FALL_B, {7'h00, m[1]});
            wr(`EIESF_IDX_RISE_B, {7'h00, m[0]});
            step(0, 1'b1, m[0]);
            step(0, 1'b0, m[1]);
        end
        // one-cycle glitch must not survive the synchroniser
        b = pc[0];
        i_pins.drive(0, 1'b1);
        i_pins.drive(0, 1'b0);
        cyc(15);
        chk(pc[0] - b, 0);
        wr(`EIESF_IDX_MASK, 8'h00);
        wr(`EIESF_IDX_STAT, 8'hFF);
        step(0, 1'b1, 1);
        chk(irq, 0);
        wr(`EIESF_IDX_MASK, 8'h01);
        chk(irq, 1);
        wr(`EIESF_IDX_STAT, 8'h01);
        chk(irq, 0);
        rdr(`EIESF_IDX_STAT);
        chk(rd, 8'h00);
        aresetn <= 1'b0;
        cyc(4);
        aresetn <= 1'b1;
        rdr(`EIESF_IDX_MASK);
        chk(rd, 8'h00);
        wr(`EIESF_IDX_RISE_A, 8'h40);
        wr(`EIESF_IDX_FCTL, 8'h85);
        cyc(128);
        b = pc[3];
        i_pins.drive(3, 1'b1);
        cyc(60);
        i_pins.drive(3, 1'b0);
        cyc(200);
        chk(pc[3] - b, 0);
        for (int c = 0; c < 6; c++) begin
            wr(`EIESF_IDX_FCTL, 8'h80 | c[7:0]);
            cyc(4 * dv[c]);
            b = pc[3];
            i_pins.drive(3, 1'b1);
            cyc(2 * dv[c] - 8);
            chk(pc[3] - b, 0);
            cyc(2 * dv[c] + 40);
            chk(pc[3] - b, 1);
            i_pins.drive(3, 1'b0);
            cyc(4 * dv[c]);
        end
        // pin 3 rose once in the pin sweep and once per sampling code
        chk(wc, 7);
        wrap_up();
    end
endmodule
